// ### inc/macsc_pkg.sv
/*
 Scan controller package: map, fields, reset values, timing, types.
 Assumes a 25 MHz core clock and a 32-bit AXI4-Lite register bus.
*/
package macsc_pkg;

    localparam int CLK_HZ = 25000000;
    localparam int NCH = 8;
    localparam int FIFO_DEPTH = 32768;
    localparam int FIFO_AW = 15;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_CMD = 8'h04;
    localparam logic [7:0] OFF_PACE = 8'h08;
    localparam logic [7:0] OFF_COUNT = 8'h0c;
    localparam logic [7:0] OFF_RANGE = 8'h10;
    localparam logic [7:0] OFF_STAT = 8'h14;
    localparam logic [7:0] OFF_DATA = 8'h18;
    localparam logic [7:0] OFF_LEVEL = 8'h1c;

    // Control fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_EXTCLK_BIT = 2;
    localparam int CTRL_TRIGEN_BIT = 3;
    localparam int CTRL_TRIGM_LSB = 4;
    localparam int CTRL_CHEN_LSB = 8;
    localparam int CTRL_SWCH_LSB = 16;

    // Command bits
    localparam int CMD_START_BIT = 0;
    localparam int CMD_STOP_BIT = 1;
    localparam int CMD_SWCONV_BIT = 2;
    localparam int CMD_CLROVR_BIT = 3;

    // Status bits
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_ARMED_BIT = 1;
    localparam int ST_OVR_BIT = 2;
    localparam int ST_SWDONE_BIT = 3;
    localparam int ST_DONE_BIT = 4;
    localparam int ST_EMPTY_BIT = 5;

    localparam logic [31:0] CTRL_RST = 32'h0000_0100;
    localparam logic [15:0] PACE_RST = 16'h00f9;
    localparam logic [15:0] COUNT_RST = 16'h0400;
    localparam logic [15:0] RANGE_RST = 16'h0000;

    // Rate limits in samples per second
    localparam int AGG_HW_SPS = 400000;
    localparam int AGG_BURST_SPS = 800000;
    localparam int PERCH_SPS = 100000;
    localparam logic [15:0] MIN_PACE_PERCH = 16'((CLK_HZ + PERCH_SPS - 1)
        / PERCH_SPS - 1);
    localparam int HW_CYC_PER_CH = (CLK_HZ + AGG_HW_SPS - 1) / AGG_HW_SPS;
    localparam int BU_CYC_PER_CH = (CLK_HZ + AGG_BURST_SPS - 1)
        / AGG_BURST_SPS;

    // Indicator timing
    localparam int BLINK_MS = 50;
    localparam int BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;
    localparam int LINK_TO_MS = 100;
    localparam int LINK_TO_CYC = CLK_HZ / 1000 * LINK_TO_MS;

    typedef enum logic [1:0] {
        MODE_SW = 2'h0,
        MODE_HW = 2'h1,
        MODE_BURST = 2'h2,
        MODE_RSVD = 2'h3
    } macsc_mode_t;

    typedef enum logic [1:0] {
        TRIG_RISE = 2'h0,
        TRIG_FALL = 2'h1,
        TRIG_HIGH = 2'h2,
        TRIG_LOW = 2'h3
    } macsc_trig_t;

    typedef struct packed {
        logic [2:0] ch;
        logic [15:0] code;
    } macsc_sample_t;

    typedef struct packed {
        logic [1:0] rng;
        logic [2:0] ch;
    } macsc_conv_t;

endpackage

// ### src/macsc_top.sv
/*
 Scan controller for an eight-channel 16-bit acquisition unit.
 Assumes converters answer each start with one done pulse.
*/
// Function
// - Software mode: one conversion per request, unbuffered.
// - Software conversion only on host command; result returned.
// - Own 16-bit converter per channel; enabled ones sampled together.
// - Host picks one of four bipolar ranges.
// - Clocked mode fills FIFO each tick until stopped, or until the FIFO would overflow (sets overrun).
// - Tick from internal or external clock.
// - Clocked rate: 400k over channels, 100k per channel.
// - Clocked scan starts on command, or trigger if enabled.
// - Burst fills memory; readout only after completion.
// - Burst: one pass, one to eight channels.
// - Triggered burst waits for trigger after start.
// - Burst count capped at memory depth.
// - Burst rate: 800k aggregate, 100k per channel.
// - Indicator steady on while link active.
// - Indicator blinks once per link command, start command or software conversion command.
// - Indicator blinks while a scan runs.
// - Indicator off on link loss, on when restored.
// - Indicator cannot be disabled.
// - Trigger on rising or falling edge, high or low level.
`timescale 1ns/10ps
`default_nettype none
module macsc_top (
    // Clock and reset
    input wire logic REF_CLK_IN,
    input wire logic NRST_IN,
    // AXI4-Lite write
    input wire logic [7:0] S_AXI_AWADDR_IN,
    input wire logic S_AXI_AWVALID_IN,
    output logic S_AXI_AWREADY_OUT,
    input wire logic [31:0] S_AXI_WDATA_IN,
    input wire logic [3:0] S_AXI_WSTRB_IN,
    input wire logic S_AXI_WVALID_IN,
    output logic S_AXI_WREADY_OUT,
    output logic [1:0] S_AXI_BRESP_OUT,
    output logic S_AXI_BVALID_OUT,
    input wire logic S_AXI_BREADY_IN,
    // AXI4-Lite read
    input wire logic [7:0] S_AXI_ARADDR_IN,
    input wire logic S_AXI_ARVALID_IN,
    output logic S_AXI_ARREADY_OUT,
    output logic [31:0] S_AXI_RDATA_OUT,
    output logic [1:0] S_AXI_RRESP_OUT,
    output logic S_AXI_RVALID_OUT,
    input wire logic S_AXI_RREADY_IN,
    // Converters
    output logic CONV_START_OUT,
    output logic [7:0] CONV_CH_EN_OUT,
    output logic [15:0] CONV_RANGE_OUT,
    input wire logic CONV_DONE_IN,
    input wire logic [127:0] CONV_DATA_IN,
    // External pacing, trigger, link, indicator
    input wire logic EXT_PACE_IN,
    input wire logic EXTERNAL_TRIGGER_INPUT_IN,
    input wire logic LINK_ACTIVE_IN,
    input wire logic LINK_CMD_IN,
    output logic STATUS_LED_OUT
);
    localparam int FIFO_AW = macsc_pkg::FIFO_AW;
    typedef enum logic [2:0] {
        S_IDLE, S_ARM, S_RUN, S_CONV, S_SWCONV, S_DRAIN
    } macsc_state_t;

    typedef struct packed {
        macsc_state_t st;
        logic awrdy, wrdy, bvalid, arrdy, rvalid;
        logic aw_got, w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic [1:0] bresp, rresp;
        logic [31:0] ctrl;
        logic [15:0] pace, count, rng;
        logic [15:0] pace_cnt;
        logic [15:0] rate_cnt;
        logic [15:0] swres;
        logic ovr, swdone, done, stop_pend;
        logic conv_start;
        logic [7:0] ch_en;
        logic [2:0] ch_idx;
        logic [127:0] lat;
        logic [FIFO_AW:0] wptr, rptr;
        logic [FIFO_AW:0] burst_left;
        logic ext_q, trig_q;
        logic [23:0] blink_cnt;
        logic blink_on;
        logic [23:0] link_cnt;
        logic link_ok;
        logic led;
    } macsc_regs_t;

    macsc_regs_t r, n;
    logic [15:0] mem [0:macsc_pkg::FIFO_DEPTH-1];
    logic [15:0] mem_q;
    logic mem_we;
    logic [macsc_pkg::FIFO_AW-1:0] mem_wa;
    logic [15:0] mem_wd;

    always_ff @(posedge REF_CLK_IN) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
        mem_q <= mem[r.rptr[macsc_pkg::FIFO_AW-1:0]];
    end

    // Helpers
    logic [3:0] nen;
    logic [15:0] min_pace;
    logic [FIFO_AW:0] level;
    logic fifo_empty, wr_go, rd_go, cmd_start, cmd_stop;
    logic cmd_sw, tick, trig_hit;
    macsc_pkg::macsc_mode_t mode;

    always_comb begin
        nen = 4'h0;
        for (int i = 0; i < 8; i++) begin
            nen = nen + {3'h0, r.ctrl[macsc_pkg::CTRL_CHEN_LSB + i]};
        end
    end

    always_comb begin
        logic [31:0] wd;
        logic [15:0] agg;
        wd = 32'h0;
        agg = 16'h0;
        n = r;
        mode = macsc_pkg::macsc_mode_t'(r.ctrl[1:0]);
        level = r.wptr - r.rptr;
        fifo_empty = (level == '0);
        // Pacing floor
        agg = (mode == macsc_pkg::MODE_BURST) ?
            16'(macsc_pkg::BU_CYC_PER_CH * nen) :
            16'(macsc_pkg::HW_CYC_PER_CH * nen);
        min_pace = (agg - 16'h1 > macsc_pkg::MIN_PACE_PERCH) ?
            agg - 16'h1 : macsc_pkg::MIN_PACE_PERCH;
        mem_we = 1'b0;
        mem_wa = r.wptr[FIFO_AW-1:0];
        mem_wd = r.lat[16*r.ch_idx +: 16];
        n.conv_start = 1'b0;
        n.ext_q = EXT_PACE_IN;
        n.trig_q = EXTERNAL_TRIGGER_INPUT_IN;
        // Trigger qualifier
        unique case (macsc_pkg::macsc_trig_t'(r.ctrl[5:4]))
            macsc_pkg::TRIG_RISE: trig_hit = EXTERNAL_TRIGGER_INPUT_IN &
                ~r.trig_q;
            macsc_pkg::TRIG_FALL: trig_hit = ~EXTERNAL_TRIGGER_INPUT_IN &
                r.trig_q;
            macsc_pkg::TRIG_HIGH: trig_hit = EXTERNAL_TRIGGER_INPUT_IN;
            macsc_pkg::TRIG_LOW: trig_hit = ~EXTERNAL_TRIGGER_INPUT_IN;
        endcase
        // Pacing tick source
        if (r.ctrl[macsc_pkg::CTRL_EXTCLK_BIT]) begin
            tick = EXT_PACE_IN & ~r.ext_q;
        end else begin
            tick = (r.pace_cnt == 16'h0);
        end
        if (r.pace_cnt == 16'h0) begin
            n.pace_cnt = (r.pace > min_pace) ? r.pace : min_pace;
        end else begin
            n.pace_cnt = r.pace_cnt - 16'h1;
        end
        // Drop ticks inside the rate floor
        if (r.rate_cnt != 16'h0) begin
            n.rate_cnt = r.rate_cnt - 16'h1;
        end
        if (tick && r.rate_cnt != 16'h0) begin
            tick = 1'b0;
        end

        // AXI write channel
        n.awrdy = ~r.aw_got & ~r.bvalid;
        n.wrdy = ~r.w_got & ~r.bvalid;
        if (S_AXI_AWVALID_IN && r.awrdy) begin
            n.aw_got = 1'b1;
            n.awaddr = S_AXI_AWADDR_IN;
            n.awrdy = 1'b0;
        end
        if (S_AXI_WVALID_IN && r.wrdy) begin
            n.w_got = 1'b1;
            n.wdata = S_AXI_WDATA_IN & {{8{S_AXI_WSTRB_IN[3]}},
                {8{S_AXI_WSTRB_IN[2]}}, {8{S_AXI_WSTRB_IN[1]}},
                {8{S_AXI_WSTRB_IN[0]}}};
            n.wrdy = 1'b0;
        end
        cmd_start = 1'b0;
        cmd_stop = 1'b0;
        cmd_sw = 1'b0;
        if (r.aw_got && r.w_got && !r.bvalid) begin
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = 2'h0;
            wd = r.wdata;
            unique case (r.awaddr)
                macsc_pkg::OFF_CTRL: n.ctrl = wd;
                macsc_pkg::OFF_PACE: n.pace = wd[15:0];
                macsc_pkg::OFF_COUNT: n.count = wd[15:0];
                macsc_pkg::OFF_RANGE: n.rng = wd[15:0];
                macsc_pkg::OFF_CMD: begin
                    cmd_start = wd[macsc_pkg::CMD_START_BIT];
                    cmd_stop = wd[macsc_pkg::CMD_STOP_BIT];
                    cmd_sw = wd[macsc_pkg::CMD_SWCONV_BIT];
                    if (wd[macsc_pkg::CMD_CLROVR_BIT]) begin
                        n.ovr = 1'b0;
                    end
                end
                default: n.bresp = 2'h2;
            endcase
        end
        if (S_AXI_BREADY_IN && r.bvalid) begin
            n.bvalid = 1'b0;
        end

        // AXI read channel
        rd_go = 1'b0;
        n.arrdy = ~r.rvalid & ~r.arrdy;
        if (S_AXI_ARVALID_IN && r.arrdy) begin
            n.arrdy = 1'b0;
            n.rvalid = 1'b1;
            n.rresp = 2'h0;
            n.rdata = 32'h0;
            unique case (S_AXI_ARADDR_IN)
                macsc_pkg::OFF_CTRL: n.rdata = r.ctrl;
                macsc_pkg::OFF_PACE: n.rdata = {16'h0, r.pace};
                macsc_pkg::OFF_COUNT: n.rdata = {16'h0, r.count};
                macsc_pkg::OFF_RANGE: n.rdata = {16'h0, r.rng};
                macsc_pkg::OFF_STAT: begin
                    n.rdata[macsc_pkg::ST_BUSY_BIT] = (r.st != S_IDLE);
                    n.rdata[macsc_pkg::ST_ARMED_BIT] = (r.st == S_ARM);
                    n.rdata[macsc_pkg::ST_OVR_BIT] = r.ovr;
                    n.rdata[macsc_pkg::ST_SWDONE_BIT] = r.swdone;
                    n.rdata[macsc_pkg::ST_DONE_BIT] = r.done;
                    n.rdata[macsc_pkg::ST_EMPTY_BIT] = fifo_empty;
                    n.rdata[31:16] = r.swres;
                    n.swdone = 1'b0;
                end
                macsc_pkg::OFF_DATA: begin
                    // Burst data withheld until capture ends
                    if (!fifo_empty && !(mode == macsc_pkg::MODE_BURST &&
                        r.st != S_IDLE)) begin
                        n.rdata = {16'h0, mem_q};
                        rd_go = 1'b1;
                    end
                end
                macsc_pkg::OFF_LEVEL: n.rdata = {{(31-FIFO_AW){1'b0}},
                    level};
                default: n.rresp = 2'h2;
            endcase
        end
        if (S_AXI_RREADY_IN && r.rvalid) begin
            n.rvalid = 1'b0;
        end
        if (rd_go) begin
            n.rptr = r.rptr + 1'b1;
        end

        // Sequencer
        wr_go = 1'b0;
        n.stop_pend = (r.stop_pend | cmd_stop) & (r.st != S_IDLE);
        unique case (r.st)
            S_IDLE: begin
                if (cmd_sw && mode == macsc_pkg::MODE_SW) begin
                    n.ch_en = 8'h1 << r.ctrl[18:16];
                    n.conv_start = 1'b1;
                    n.st = S_SWCONV;
                end else if (cmd_start && nen != 4'h0 &&
                    mode != macsc_pkg::MODE_SW) begin
                    n.ch_en = r.ctrl[15:8];
                    n.done = 1'b0;
                    n.burst_left = (r.count == 16'h0 || {1'b0, r.count} >
                        17'(macsc_pkg::FIFO_DEPTH / nen)) ?
                        (FIFO_AW+1)'(macsc_pkg::FIFO_DEPTH / nen) :
                        (FIFO_AW+1)'(r.count);
                    if (mode == macsc_pkg::MODE_BURST) begin
                        n.wptr = '0;
                        n.rptr = '0;
                    end
                    n.st = r.ctrl[macsc_pkg::CTRL_TRIGEN_BIT] ?
                        S_ARM : S_RUN;
                end
            end
            S_SWCONV: begin
                if (CONV_DONE_IN) begin
                    n.swres = CONV_DATA_IN[16*r.ctrl[18:16] +: 16];
                    n.swdone = 1'b1;
                    n.st = S_IDLE;
                end
            end
            S_ARM: begin
                if (cmd_stop) begin
                    n.st = S_IDLE;
                end else if (trig_hit) begin
                    n.st = S_RUN;
                end
            end
            S_RUN: begin
                if (cmd_stop || r.stop_pend) begin
                    n.st = S_IDLE;
                end else if (tick) begin
                    n.rate_cnt = min_pace;
                    if (mode == macsc_pkg::MODE_HW &&
                        level > (FIFO_AW+1)'(macsc_pkg::FIFO_DEPTH - nen))
                        begin
                        n.ovr = 1'b1;
                        n.st = S_IDLE;
                    end else begin
                        n.conv_start = 1'b1;
                        n.st = S_CONV;
                    end
                end
            end
            S_CONV: begin
                if (CONV_DONE_IN) begin
                    n.lat = CONV_DATA_IN;
                    n.ch_idx = 3'h0;
                    n.st = S_DRAIN;
                end
            end
            S_DRAIN: begin
                if (r.ch_en[r.ch_idx]) begin
                    mem_we = 1'b1;
                    wr_go = 1'b1;
                end
                n.ch_idx = r.ch_idx + 3'h1;
                if (r.ch_idx == 3'h7) begin
                    if (mode == macsc_pkg::MODE_BURST) begin
                        n.burst_left = r.burst_left - 1'b1;
                        // Single pass; no automatic rearm
                        n.st = (r.burst_left == 1) ? S_IDLE : S_RUN;
                        n.done = (r.burst_left == 1);
                    end else begin
                        n.st = S_RUN;
                    end
                end
            end
            default: n.st = S_IDLE;
        endcase
        if (wr_go) begin
            n.wptr = r.wptr + 1'b1;
        end

        // Indicator
        if (LINK_ACTIVE_IN) begin
            n.link_cnt = 24'(macsc_pkg::LINK_TO_CYC);
            n.link_ok = 1'b1;
        end else if (r.link_cnt != 24'h0) begin
            n.link_cnt = r.link_cnt - 24'h1;
        end else begin
            n.link_ok = 1'b0;
        end
        if (LINK_CMD_IN || cmd_start || cmd_sw) begin
            n.blink_cnt = 24'(2 * macsc_pkg::BLINK_CYC);
        end else if (r.blink_cnt != 24'h0) begin
            n.blink_cnt = r.blink_cnt - 24'h1;
        end else if (r.st != S_IDLE && r.st != S_SWCONV) begin
            n.blink_cnt = 24'(2 * macsc_pkg::BLINK_CYC);
        end
        n.blink_on = (n.blink_cnt > 24'(macsc_pkg::BLINK_CYC));
        // No enable gates this output
        n.led = n.link_ok & ~n.blink_on;
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (!NRST_IN) begin
            r <= '0;
            r.st <= S_IDLE;
            r.ctrl <= macsc_pkg::CTRL_RST;
            r.pace <= macsc_pkg::PACE_RST;
            r.count <= macsc_pkg::COUNT_RST;
            r.rng <= macsc_pkg::RANGE_RST;
        end else begin
            r <= n;
        end
    end

    assign S_AXI_AWREADY_OUT = r.awrdy;
    assign S_AXI_WREADY_OUT = r.wrdy;
    assign S_AXI_BRESP_OUT = r.bresp;
    assign S_AXI_BVALID_OUT = r.bvalid;
    assign S_AXI_ARREADY_OUT = r.arrdy;
    assign S_AXI_RDATA_OUT = r.rdata;
    assign S_AXI_RRESP_OUT = r.rresp;
    assign S_AXI_RVALID_OUT = r.rvalid;
    assign CONV_START_OUT = r.conv_start;
    assign CONV_CH_EN_OUT = r.ch_en;
    assign CONV_RANGE_OUT = r.rng;
    assign STATUS_LED_OUT = r.led;
endmodule
`default_nettype wire

// ### tb/macsc_chk.sv
/*
 Checker for the scan controller's bus and converter ports.
 Bound into macsc_top; sees its ports only.
*/
`timescale 1ns/10ps
`default_nettype none
module macsc_chk (
    // Clock and reset
    input wire logic REF_CLK_IN,
    input wire logic NRST_IN,
    // Register bus
    input wire logic S_AXI_AWREADY_OUT,
    input wire logic S_AXI_WREADY_OUT,
    input wire logic S_AXI_BVALID_OUT,
    input wire logic S_AXI_BREADY_IN,
    input wire logic [7:0] S_AXI_ARADDR_IN,
    input wire logic S_AXI_ARVALID_IN,
    input wire logic S_AXI_ARREADY_OUT,
    input wire logic [31:0] S_AXI_RDATA_OUT,
    input wire logic [1:0] S_AXI_RRESP_OUT,
    input wire logic S_AXI_RVALID_OUT,
    input wire logic S_AXI_RREADY_IN,
    // Converters
    input wire logic CONV_START_OUT,
    input wire logic [7:0] CONV_CH_EN_OUT,
    input wire logic [15:0] CONV_RANGE_OUT
);
    logic [7:0] gap_r;
    logic ar_take;

    // Cycles since the last sample set, saturating
    always_ff @(posedge REF_CLK_IN) begin
        if (!NRST_IN) begin
            gap_r <= 8'hff;
        end else if (CONV_START_OUT) begin
            gap_r <= 8'h00;
        end else if (gap_r != 8'hff) begin
            gap_r <= gap_r + 8'h01;
        end
    end
    assign ar_take = S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT;

    default clocking @(posedge REF_CLK_IN); endclocking
    default disable iff (!NRST_IN);

    property p_start_pulse;
        CONV_START_OUT |=> !CONV_START_OUT;
    endproperty
    a_start_pulse: assert property (p_start_pulse)
        else $error("Start pulse longer than one cycle");
    property p_start_chan;
        CONV_START_OUT |-> CONV_CH_EN_OUT != 8'h00;
    endproperty
    a_start_chan: assert property (p_start_chan)
        else $error("Start with no channel enabled");
    property p_set_stable;
        CONV_START_OUT |=> $stable(CONV_CH_EN_OUT) && $stable(CONV_RANGE_OUT);
    endproperty
    a_set_stable: assert property (p_set_stable)
        else $error("Channel or range moved during a conversion");
    property p_rate;
        CONV_START_OUT |-> gap_r >= 8'hf9;
    endproperty
    a_rate: assert property (p_rate)
        else $error("Sample sets closer than the rate ceiling");
    property p_b_hold;
        S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=> S_AXI_BVALID_OUT;
    endproperty
    a_b_hold: assert property (p_b_hold)
        else $error("Write response dropped early");
    property p_r_hold;
        S_AXI_RVALID_OUT && !S_AXI_RREADY_IN
            |=> S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT);
    endproperty
    a_r_hold: assert property (p_r_hold)
        else $error("Read data not held");
    property p_ar_bad;
        ar_take && S_AXI_ARADDR_IN > 8'h1f
            |=> S_AXI_RVALID_OUT && S_AXI_RRESP_OUT == 2'h2;
    endproperty
    a_ar_bad: assert property (p_ar_bad)
        else $error("Unmapped read not refused");
    property p_ar_ok;
        ar_take && S_AXI_ARADDR_IN[1:0] == 2'h0 && S_AXI_ARADDR_IN <= 8'h1c
            |=> S_AXI_RVALID_OUT && S_AXI_RRESP_OUT == 2'h0;
    endproperty
    a_ar_ok: assert property (p_ar_ok)
        else $error("Mapped read not answered in time");
    property p_busy;
        S_AXI_BVALID_OUT |-> !S_AXI_AWREADY_OUT && !S_AXI_WREADY_OUT;
    endproperty
    a_busy: assert property (p_busy)
        else $error("Write accepted while response pending");

    c_start: cover property (CONV_START_OUT);
    c_slverr: cover property (S_AXI_RVALID_OUT && S_AXI_RRESP_OUT == 2'h2);
    c_write: cover property (S_AXI_BVALID_OUT && S_AXI_BREADY_IN);
endmodule
bind macsc_top macsc_chk macsc_chk_i (
    .REF_CLK_IN(REF_CLK_IN), .NRST_IN(NRST_IN),
    .S_AXI_AWREADY_OUT(S_AXI_AWREADY_OUT),
    .S_AXI_WREADY_OUT(S_AXI_WREADY_OUT),
    .S_AXI_BVALID_OUT(S_AXI_BVALID_OUT), .S_AXI_BREADY_IN(S_AXI_BREADY_IN),
    .S_AXI_ARADDR_IN(S_AXI_ARADDR_IN), .S_AXI_ARVALID_IN(S_AXI_ARVALID_IN),
    .S_AXI_ARREADY_OUT(S_AXI_ARREADY_OUT),
    .S_AXI_RDATA_OUT(S_AXI_RDATA_OUT), .S_AXI_RRESP_OUT(S_AXI_RRESP_OUT),
    .S_AXI_RVALID_OUT(S_AXI_RVALID_OUT), .S_AXI_RREADY_IN(S_AXI_RREADY_IN),
    .CONV_START_OUT(CONV_START_OUT), .CONV_CH_EN_OUT(CONV_CH_EN_OUT),
    .CONV_RANGE_OUT(CONV_RANGE_OUT)
);
`default_nettype wire

// ### tb/macsc_conv_model.sv
/*
 Converter bank model: answers each start pulse with one done pulse.
 Assumes start is a one-cycle pulse on the design clock.
*/
`timescale 1ns/10ps
`default_nettype none
module macsc_conv_model #(
    parameter int DELAY = 3
) (
    // Clock
    input wire logic clk_in,
    // Converter side
    input wire logic start_in,
    output logic done_out,
    output logic [127:0] data_out
);
    int nset = 0;
    int cnt = 0;
    logic [127:0] res = '0;

    initial begin
        done_out = 1'b0;
        data_out = '0;
    end

    // Result lines hold garbage outside the done cycle
    always @(posedge clk_in) begin
        done_out <= 1'b0;
        data_out <= ~res;
        if (start_in) begin
            for (int i = 0; i < 8; i++) begin
                res[16*i +: 16] = {4'(i), 12'(nset)};
            end
            nset++;
            cnt = DELAY;
        end else if (cnt > 0) begin
            cnt--;
            if (cnt == 0) begin
                done_out <= 1'b1;
                data_out <= res;
            end
        end
    end
endmodule
`default_nettype wire

// ### tb/macsc_top_test.sv
/*
 Testbench for macsc_top: bus tasks and scenarios.
 Assumes the converter model beside it.
*/
`timescale 1ns/10ps
`default_nettype none
module macsc_top_test;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic awvalid = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic [7:0] araddr = 8'h00;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic ext_pace = 1'b0;
    logic trig = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, conv_start, conv_done;
    logic led;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, rd_v;
    logic [7:0] ch_en, last_en;
    logic [15:0] rng, last_rng;
    logic [127:0] conv_data;
    int errors = 0;
    int tests_run = 0;
    int starts = 0;
    int s0, n, c, lv;

    always #20 clk = ~clk;

    macsc_top macsc_top_i (
        .REF_CLK_IN(clk), .NRST_IN(nrst),
        .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid),
        .S_AXI_AWREADY_OUT(awready), .S_AXI_WDATA_IN(wdata),
        .S_AXI_WSTRB_IN(4'hf), .S_AXI_WVALID_IN(wvalid),
        .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp),
        .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready),
        .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
        .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata),
        .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid),
        .S_AXI_RREADY_IN(rready), .CONV_START_OUT(conv_start),
        .CONV_CH_EN_OUT(ch_en), .CONV_RANGE_OUT(rng),
        .CONV_DONE_IN(conv_done), .CONV_DATA_IN(conv_data),
        .EXT_PACE_IN(ext_pace), .EXTERNAL_TRIGGER_INPUT_IN(trig),
        .LINK_ACTIVE_IN(1'b1), .LINK_CMD_IN(1'b0), .STATUS_LED_OUT(led)
    );
    macsc_conv_model #(.DELAY(3)) macsc_conv_model_i (
        .clk_in(clk), .start_in(conv_start),
        .done_out(conv_done), .data_out(conv_data)
    );

    always @(posedge clk) begin
        if (conv_start === 1'b1) begin
            starts++;
            last_en = ch_en;
            last_rng = rng;
        end
    end

    task automatic stop_test();
        if (errors == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'h7;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rd_v = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e,
        input string nm);
        rd(a);
        chk(nm, e, rd_v);
    endtask

    task automatic poll(input int b);
        n = 0;
        rd_v = 32'h0;
        while (rd_v[b] !== 1'b1 && n < 400) begin
            rd(8'h14);
            n++;
        end
    endtask

    initial begin
        repeat (40000) @(posedge clk);
        errors++;
        stop_test();
    end

    initial begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        repeat (5) @(posedge clk);
        chk("led", 32'h1, 32'(led));
        rc(8'h00, 32'h0000_0100, "ctrl");
        rc(8'h08, 32'h0000_00f9, "pace");
        rc(8'h0c, 32'h0000_0400, "count");
        rc(8'h10, 32'h0, "range");
        rc(8'h14, 32'h0000_0020, "status");
        rd(8'h20);
        chk("rresp", 32'h2, 32'(resp));
        wr(8'h40, 32'h1);
        chk("bresp", 32'h2, 32'(resp));
        for (int r = 0; r < 4; r++) begin
            c = 2 * r + 1;
            wr(8'h10, {16'h0, {8{2'(r)}}});
            wr(8'h00, 32'h100 | (c << 16));
            s0 = starts;
            wr(8'h04, 32'h4);
            poll(3);
            chk("result", {16'h0, 4'(c), 12'(s0)}, rd_v[31:16]);
            chk("starts", 32'(s0 + 1), 32'(starts));
            chk("chen", 32'(8'h1 << c), 32'(last_en));
            chk("range", {8{2'(r)}}, last_rng);
            repeat (260) @(posedge clk);
        end
        rc(8'h1c, 32'h0, "level");
        lv = 0;
        for (int m = 0; m < 4; m++) begin
            trig <= 1'(m);
            wr(8'h00, 32'h0f09 | (m << 4));
            s0 = starts;
            wr(8'h04, 32'h1);
            repeat (600) @(posedge clk);
            chk("armed", 32'(s0), 32'(starts));
            trig <= ~1'(m);
            repeat (1100) @(posedge clk);
            wr(8'h04, 32'h2);
            repeat (50) @(posedge clk);
            trig <= 1'(m);
            chk("sets", 32'h1, 32'(starts > s0 + 2));
            lv = lv + 4 * (starts - s0);
            rc(8'h1c, 32'(lv), "level");
            repeat (260) @(posedge clk);
        end
        wr(8'h00, 32'h0f05);
        s0 = starts;
        wr(8'h04, 32'h1);
        repeat (3) begin
            ext_pace <= 1'b1;
            repeat (150) @(posedge clk);
            ext_pace <= 1'b0;
            repeat (150) @(posedge clk);
        end
        wr(8'h04, 32'h2);
        repeat (50) @(posedge clk);
        chk("ext ticks", 32'(s0 + 3), 32'(starts));
        rc(8'h1c, 32'(lv + 12), "level");
        repeat (260) @(posedge clk);
        trig <= 1'b0;
        wr(8'h0c, 32'h3);
        wr(8'h00, 32'hff0a);
        s0 = starts;
        wr(8'h04, 32'h1);
        repeat (400) @(posedge clk);
        chk("held", 32'(s0), 32'(starts));
        trig <= 1'b1;
        repeat (300) @(posedge clk);
        rc(8'h18, 32'h0, "early data");
        poll(4);
        repeat (600) @(posedge clk);
        chk("burst sets", 32'(s0 + 3), 32'(starts));
        chk("burst chen", 32'h0000_00ff, 32'(last_en));
        rc(8'h1c, 32'd24, "burst level");
        stop_test();
    end
endmodule
`default_nettype wire
